/* File: mbs_frame_engine.sv */
// rtu slave frame engine: framing, crc, register and relay commands, replies
//
// Overview of operation
// - 03h reads, 10h writes consecutive registers
// - 01h reports relay, 05h sets relay
// - check appended crc, drop mismatching frames
// - crc accumulator starts at all ones
// - xor byte into accumulator low byte
// - shift right, xor polynomial on one
// - eight shifts per byte, final value
// - read query and reply frame layout
// - write query; reply echoes header, crc
// - register words sent high byte first
// - crc trails frame, low byte first
// - error reply: address, flagged code, code
// - code 81 for unsupported function
// - code 82 for out of range location
// - code 83 for out of range value
// - 32-bit values, high word lower address
// - two zero words clear energy count
// - answer own address only, else silent
`timescale 1ns/1ps
module mbs_frame_engine
  import mbs_pkg::*;
#(
  parameter int GAP_CYCLES = GAP_CYCLES_DEF          // idle gap in clocks
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // received bytes from the uart
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  // bytes to the uart transmitter
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  output logic             tx_en,
  // configuration
  input  wire logic [7:0]  slave_addr,
  // register file
  output logic [15:0]      reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rd_ok,
  input  wire logic        reg_wr_addr_ok,
  input  wire logic        reg_wr_val_ok,
  // relay and energy control
  output logic             relay_out,
  output logic             energy_clear
);

  localparam logic [GAP_CNT_W-1:0] GAP_LAST = GAP_CNT_W'(GAP_CYCLES - 1);

  mbs_state_e           state;                       // engine state
  logic [7:0]           rxb [0:BUF_DEPTH-1];         // query bytes
  logic [7:0]           txb [0:BUF_DEPTH-1];         // reply bytes before crc
  logic [5:0]           rx_len;                      // bytes received
  logic                 rx_ovf;                      // query longer than buffer
  logic [15:0]          rx_crc;                      // running crc of query
  logic [GAP_CNT_W-1:0] gap_cnt;                     // idle clocks since last byte
  logic                 in_frame;                    // at least one byte seen
  logic [5:0]           idx;                         // word or byte index
  logic [5:0]           tx_len;                      // reply length before crc
  logic [15:0]          tx_crc;                      // running crc of reply
  logic [7:0]           exc;                         // pending error code

  // word of two query bytes, high byte first
  function automatic logic [15:0] rx_word(input logic [5:0] p);
    return {rxb[p], rxb[p + 6'h01]};
  endfunction

  // query field decode
  wire [7:0]  fc        = rxb[POS_FC];
  wire [15:0] start     = rx_word(POS_START);
  wire [15:0] cnt       = rx_word(POS_CNT);
  wire [7:0]  bcnt      = rxb[POS_BCNT];
  wire [15:0] word0     = rx_word(POS_WDATA);
  wire [5:0]  nidx      = idx + 6'h01;
  wire [5:0]  nw_pos    = POS_WDATA + {nidx[4:0], 1'b0};
  wire [15:0] word_next = rx_word(nw_pos);
  wire [5:0]  cnt_last  = cnt[5:0] - 6'h01;
  wire        idx_last  = (idx == cnt_last);
  wire [5:0]  rd_pos    = POS_RDATA + {idx[4:0], 1'b0};
  wire [5:0]  rd_pos_lo = rd_pos + 6'h01;
  wire [5:0]  rd_len    = POS_RDATA + {cnt[4:0], 1'b0};
  wire [7:0]  rd_bc     = {cnt[6:0], 1'b0};

  // frame acceptance
  // residual is zero only for a good check field
  wire crc_ok    = (rx_crc == CRC_RESIDUAL);
  // own address only; zero never answered
  wire addr_ok   = (rxb[POS_ADDR] == slave_addr) && (slave_addr != 8'h00);
  wire fc_wr     = (fc == FC_WRITE_REGS);
  wire fc_known  = fc_wr || (fc == FC_READ_REGS) || (fc == FC_READ_RELAY) || (fc == FC_WRITE_RELAY);
  wire len_match = fc_wr ? ({3'h0, rx_len} == LEN_WR_HDR + {1'b0, bcnt}) : (rx_len == LEN_FIXED);
  wire frame_ok  = crc_ok && addr_ok && !rx_ovf && (rx_len >= LEN_MIN) && (len_match || !fc_known);
  wire cnt_ok    = (cnt != 16'h0000) && (cnt <= MAX_REGS);
  wire bc_ok     = ({cnt[14:0], 1'b0} == {8'h00, bcnt});
  // relay value sits where a register query carries its count
  wire rly_val   = (cnt == RELAY_ON) || (cnt == RELAY_OFF);
  // two zero words at the energy pair
  wire clear_hit = (start == ENERGY_HI_ADDR) && (cnt == ENERGY_WORDS) && (word0 == 16'h0000)
                   && (rx_word(POS_WDATA2) == 16'h0000);

  // transmit path into the fifo
  wire       fifo_in_valid = (state == ST_SEND) || (state == ST_CRCL) || (state == ST_CRCH);
  wire       fifo_in_ready;
  // check field low byte goes first
  wire [7:0] fifo_in_data  = (state == ST_CRCL) ? tx_crc[7:0] :
                             (state == ST_CRCH) ? tx_crc[15:8] : txb[idx];
  wire       fifo_take     = fifo_in_valid && fifo_in_ready;

  // main sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= ST_RX;
      rx_len       <= '0;
      rx_ovf       <= 1'b0;
      rx_crc       <= CRC_INIT;
      gap_cnt      <= '0;
      in_frame     <= 1'b0;
      idx          <= '0;
      tx_len       <= '0;
      tx_crc       <= CRC_INIT;
      exc          <= 8'h00;
      reg_addr     <= 16'h0000;
      reg_wdata    <= 16'h0000;
      reg_wr       <= 1'b0;
      relay_out    <= 1'b0;
      energy_clear <= 1'b0;
    end else begin
      reg_wr       <= 1'b0;
      energy_clear <= 1'b0;
      case (state)
        ST_RX: begin
          // bytes outside this state are ignored: the line is half duplex
          if (rx_valid) begin
            rx_crc   <= crc_byte(rx_crc, rx_data);
            gap_cnt  <= '0;
            in_frame <= 1'b1;
            if (rx_len == BUF_FULL) begin
              rx_ovf <= 1'b1;
            end else begin
              rx_len <= rx_len + 6'h01;
            end
          end else if (in_frame) begin
            if (gap_cnt == GAP_LAST) begin
              gap_cnt <= '0;
              state   <= ST_CHK;
            end else begin
              gap_cnt <= gap_cnt + GAP_CNT_W'(1);
            end
          end
        end
        ST_CHK: begin
          // preset both accumulators for the next use
          rx_crc    <= CRC_INIT;
          tx_crc    <= CRC_INIT;
          rx_len    <= '0;
          rx_ovf    <= 1'b0;
          in_frame  <= 1'b0;
          idx       <= '0;
          reg_addr  <= start;
          reg_wdata <= word0;
          if (!frame_ok) begin
            // bad frames are dropped without a reply
            state <= ST_RX;
          end else begin
            case (fc)
              FC_READ_REGS: begin
                exc   <= EXC_VALUE;
                state <= cnt_ok ? ST_RD : ST_EXC;
              end
              // write registers, values checked before any write
              FC_WRITE_REGS: begin
                exc   <= EXC_VALUE;
                state <= (cnt_ok && bc_ok) ? ST_WCHK : ST_EXC;
              end
              FC_READ_RELAY: begin
                exc    <= EXC_ADDR;
                tx_len <= LEN_RELAY_RD;
                state  <= ((start == RELAY_ADDR) && (cnt == RELAY_COUNT)) ? ST_SEND : ST_EXC;
              end
              FC_WRITE_RELAY: begin
                tx_len <= LEN_ECHO;
                if (start != RELAY_ADDR) begin
                  exc   <= EXC_ADDR;
                  state <= ST_EXC;
                end else if (!rly_val) begin
                  exc   <= EXC_VALUE;
                  state <= ST_EXC;
                end else begin
                  relay_out <= (cnt == RELAY_ON);
                  state     <= ST_SEND;
                end
              end
              default: begin
                exc   <= EXC_FUNC;
                state <= ST_EXC;
              end
            endcase
          end
        end
        ST_RD: begin
          if (!reg_rd_ok) begin
            exc   <= EXC_ADDR;
            state <= ST_EXC;
          end else if (idx_last) begin
            idx    <= '0;
            tx_len <= rd_len;
            state  <= ST_SEND;
          end else begin
            // consecutive addresses keep wide values in order
            idx      <= idx + 6'h01;
            reg_addr <= reg_addr + 16'h0001;
          end
        end
        ST_WCHK: begin
          // a rejected word leaves every register untouched
          if (!reg_wr_addr_ok) begin
            exc   <= EXC_ADDR;
            state <= ST_EXC;
          end else if (!reg_wr_val_ok) begin
            exc   <= EXC_VALUE;
            state <= ST_EXC;
          end else if (idx_last) begin
            idx       <= '0;
            reg_addr  <= start;
            reg_wdata <= word0;
            reg_wr    <= 1'b1;
            state     <= ST_WR;
          end else begin
            idx       <= idx + 6'h01;
            reg_addr  <= reg_addr + 16'h0001;
            reg_wdata <= word_next;
          end
        end
        ST_WR: begin
          if (idx_last) begin
            // pulse the energy clear one cycle after the last write
            energy_clear <= clear_hit;
            idx          <= '0;
            tx_len       <= LEN_ECHO;
            state        <= ST_SEND;
          end else begin
            idx       <= idx + 6'h01;
            reg_addr  <= reg_addr + 16'h0001;
            reg_wdata <= word_next;
            reg_wr    <= 1'b1;
          end
        end
        ST_EXC: begin
          idx    <= '0;
          tx_len <= LEN_EXC;
          state  <= ST_SEND;
        end
        ST_SEND: begin
          if (fifo_take) begin
            tx_crc <= crc_byte(tx_crc, txb[idx]);
            if (idx == tx_len - 6'h01) begin
              state <= ST_CRCL;
            end else begin
              idx <= idx + 6'h01;
            end
          end
        end
        ST_CRCL: begin
          if (fifo_take) begin
            state <= ST_CRCH;
          end
        end
        ST_CRCH: begin
          if (fifo_take) begin
            idx   <= '0;
            state <= ST_RX;
          end
        end
        default: begin
          state <= ST_RX;
        end
      endcase
    end
  end

  // query byte store; data only, so no reset is needed
  always_ff @(posedge clk) begin
    if ((state == ST_RX) && rx_valid && (rx_len != BUF_FULL)) begin
      rxb[rx_len] <= rx_data;
    end
  end

  // reply assembly; header and echo are prepared on every accepted frame
  always_ff @(posedge clk) begin
    if (state == ST_CHK) begin
      txb[POS_ADDR] <= slave_addr;
      txb[POS_FC]   <= fc;
      for (int k = POS_ECHO_LO; k <= POS_ECHO_HI; k++) begin
        txb[k] <= rxb[k];
      end
      if (fc == FC_READ_RELAY) begin
        txb[POS_RPL_BC]  <= RELAY_BYTES;
        txb[POS_RLY_VAL] <= {7'h00, relay_out};
      end
    end
    if ((state == ST_RD) && reg_rd_ok) begin
      txb[rd_pos]    <= reg_rdata[15:8];
      txb[rd_pos_lo] <= reg_rdata[7:0];
      if (idx_last) begin
        txb[POS_RPL_BC] <= rd_bc;
      end
    end
    if (state == ST_EXC) begin
      // function code with top bit set, then code
      txb[POS_FC]  <= fc | FC_ERR_FLAG;
      txb[POS_EXC] <= exc;
    end
  end

  // driver enable spans the whole reply; the uart must cover its last stop bit itself
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_en <= 1'b0;
    end else begin
      tx_en <= fifo_in_valid || tx_valid;
    end
  end

  // reply bytes queue here so a slow transmitter stalls the sequencer
  mbs_fifo #(
    .W (BYTE_W),
    .D (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

endmodule // mbs_frame_engine

/* File: mbs_pkg.sv */
// constants, state codes and crc step shared by the slave frame engine
package mbs_pkg;

  // clock and line gap timing
  localparam int CLK_PERIOD_NS  = 10;                 // 100 mhz system clock
  localparam int GAP_TIME_US    = 4011;               // 3.5 chars of 11 bits at 9600 baud, rounded up
  localparam int GAP_CYCLES_DEF = (GAP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CNT_W      = 20;                 // wide enough for the default gap

  // crc16 constants
  localparam logic [15:0] CRC_INIT     = 16'hffff;    // accumulator preset
  localparam logic [15:0] CRC_POLY     = 16'ha001;    // reflected polynomial
  localparam logic [15:0] CRC_RESIDUAL = 16'h0000;    // crc over a frame plus its own check field
  localparam int          CRC_SHIFTS   = 8;           // shift steps per byte

  // function codes and error replies
  localparam logic [7:0] FC_READ_REGS   = 8'h03;
  localparam logic [7:0] FC_WRITE_REGS  = 8'h10;
  localparam logic [7:0] FC_READ_RELAY  = 8'h01;
  localparam logic [7:0] FC_WRITE_RELAY = 8'h05;
  localparam logic [7:0] FC_ERR_FLAG    = 8'h80;
  localparam logic [7:0] EXC_FUNC       = 8'h81;      // unsupported function
  localparam logic [7:0] EXC_ADDR       = 8'h82;      // location out of range
  localparam logic [7:0] EXC_VALUE      = 8'h83;      // value out of range

  // frame buffer geometry and byte positions
  localparam int         BUF_DEPTH   = 48;
  localparam logic [5:0] BUF_FULL    = 6'h30;         // byte count at which the buffer is full
  localparam logic [5:0] POS_ADDR    = 6'h00;
  localparam logic [5:0] POS_FC      = 6'h01;
  localparam logic [5:0] POS_START   = 6'h02;
  localparam logic [5:0] POS_CNT     = 6'h04;
  localparam logic [5:0] POS_BCNT    = 6'h06;
  localparam logic [5:0] POS_WDATA   = 6'h07;
  localparam logic [5:0] POS_WDATA2  = 6'h09;
  localparam logic [5:0] POS_RPL_BC  = 6'h02;         // byte count in a read reply
  localparam logic [5:0] POS_RDATA   = 6'h03;         // first data byte in a read reply
  localparam logic [5:0] POS_EXC     = 6'h02;
  localparam logic [5:0] POS_ECHO_LO = 6'h02;
  localparam logic [5:0] POS_ECHO_HI = 6'h05;
  localparam logic [5:0] POS_RLY_VAL = 6'h03;

  // frame lengths, crc included for queries, excluded for replies
  localparam logic [5:0] LEN_MIN      = 6'h04;
  localparam logic [5:0] LEN_FIXED    = 6'h08;
  localparam logic [8:0] LEN_WR_HDR   = 9'h009;
  localparam logic [5:0] LEN_EXC      = 6'h03;
  localparam logic [5:0] LEN_RELAY_RD = 6'h04;
  localparam logic [5:0] LEN_ECHO     = 6'h06;

  // register and relay limits
  localparam logic [15:0] MAX_REGS       = 16'h0010;
  localparam logic [15:0] RELAY_ADDR     = 16'h0000;
  localparam logic [15:0] RELAY_ON       = 16'hff00;
  localparam logic [15:0] RELAY_OFF      = 16'h0000;
  localparam logic [15:0] RELAY_COUNT    = 16'h0001;
  localparam logic [7:0]  RELAY_BYTES    = 8'h01;
  localparam logic [15:0] ENERGY_HI_ADDR = 16'h000c;
  localparam logic [15:0] ENERGY_WORDS   = 16'h0002;

  // transmit fifo
  localparam int TX_FIFO_DEPTH = 8;
  localparam int BYTE_W        = 8;

  // engine states
  typedef enum logic [8:0] {
    ST_RX   = 9'h001,
    ST_CHK  = 9'h002,
    ST_RD   = 9'h004,
    ST_WCHK = 9'h008,
    ST_WR   = 9'h010,
    ST_EXC  = 9'h020,
    ST_SEND = 9'h040,
    ST_CRCL = 9'h080,
    ST_CRCH = 9'h100
  } mbs_state_e;

  // one byte through the crc accumulator
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] acc;
    acc = crc ^ {8'h00, b};
    for (int i = 0; i < CRC_SHIFTS; i++) begin
      acc = acc[0] ? ((acc >> 1) ^ CRC_POLY) : (acc >> 1);
    end
    return acc;
  endfunction

endpackage

/* File: mbs_fifo.sv */
// shift-register byte fifo with registered outputs
`timescale 1ns/1ps
module mbs_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // filling side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // draining side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int CW = $clog2(D) + 1;                 // count width, holds 0..D
  localparam logic [CW-1:0] CNT_ONE  = CW'(1);
  localparam logic [CW-1:0] CNT_FULL = CW'(D);

  logic [W-1:0]  mem [0:D-1];                        // entry 0 is the head
  logic [CW-1:0] count;                              // words held
  logic          full;                               // registered full flag
  logic [CW-1:0] next_count;
  wire           push = in_valid & ~full;
  wire           pop  = out_valid & out_ready;

  assign in_ready   = ~full;
  assign out_data   = mem[0];
  assign next_count = count + (push ? CNT_ONE : '0) - (pop ? CNT_ONE : '0);

  // occupancy and flags; flags are flops so the head stays glitch free
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count     <= '0;
      full      <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      count     <= next_count;
      full      <= (next_count == CNT_FULL);
      out_valid <= (next_count != '0);
    end
  end

  // each entry shifts down on pop and takes the new word at the tail
  for (genvar k = 0; k < D; k++) begin : g_entry
    localparam logic [CW-1:0] KPOS = CW'(k);
    wire [W-1:0] upper = (k < D - 1) ? mem[(k < D - 1) ? k + 1 : k] : mem[k];
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        mem[k] <= '0;
      end else if (pop) begin
        // tail moves one down when popping
        mem[k] <= (push && (KPOS == count - CNT_ONE)) ? in_data : upper;
      end else if (push && (KPOS == count)) begin
        mem[k] <= in_data;
      end
    end
  end

endmodule // mbs_fifo

/* File: mbs_frame_engine_sva.sv */
// port checker for the slave frame engine
`timescale 1ns/1ps
module mbs_frame_engine_chk #(
  parameter int GAP_CYCLES = 20 // idle gap in clocks
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // line side
  input wire logic        rx_valid,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  input wire logic        tx_en,
  // register side
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_wr_addr_ok,
  input wire logic        reg_wr_val_ok,
  input wire logic        relay_out,
  input wire logic        energy_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // idle clocks since the last byte; saturates so long pauses never wrap
  logic [19:0] idle_cnt;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) idle_cnt <= '0;
    else if (rx_valid) idle_cnt <= '0;
    else if (idle_cnt != '1) idle_cnt <= idle_cnt + 20'h1;
  end
  // two zero words landing on the energy pair
  sequence s_zero_pair;
    (reg_wr && reg_addr == 16'h000c && reg_wdata == 16'h0000) ##1
    (reg_wr && reg_addr == 16'h000d && reg_wdata == 16'h0000);
  endsequence
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte dropped while stalled");
  property p_txen_cover;
    tx_valid |-> tx_en;
  endproperty
  a_txen_cover: assert property (p_txen_cover) else $error("byte offered with driver off");
  property p_reply_gap;
    $rose(tx_en) |-> idle_cnt >= GAP_CYCLES;
  endproperty
  a_reply_gap: assert property (p_reply_gap) else $error("reply before idle gap");
  property p_wr_gap;
    reg_wr |-> idle_cnt >= GAP_CYCLES;
  endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("write before frame ended");
  property p_wr_ok;
    reg_wr |-> reg_wr_addr_ok && reg_wr_val_ok;
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("write to refused place or value");
  property p_wr_consec;
    reg_wr && $past(reg_wr) |-> reg_addr == $past(reg_addr) + 16'h0001;
  endproperty
  a_wr_consec: assert property (p_wr_consec) else $error("write burst not consecutive");
  property p_clear;
    s_zero_pair |=> energy_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("energy not cleared");
  property p_clear_cause;
    energy_clear |-> $past(reg_wr) && $past(reg_addr) == 16'h000d;
  endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("stray energy clear");
  property p_relay_gap;
    $changed(relay_out) |-> idle_cnt >= GAP_CYCLES && !reg_wr;
  endproperty
  a_relay_gap: assert property (p_relay_gap) else $error("relay moved outside a command");
endmodule // mbs_frame_engine_chk
bind mbs_frame_engine mbs_frame_engine_chk #(.GAP_CYCLES(GAP_CYCLES)) u_chk (.clk, .sys_rst, .rx_valid,
  .tx_valid, .tx_data, .tx_ready, .tx_en, .reg_addr, .reg_wdata, .reg_wr, .reg_wr_addr_ok,
  .reg_wr_val_ok, .relay_out, .energy_clear);

/* File: mbs_master_model.sv */
// rtu master model: sends queries, drains replies
`timescale 1ns/1ps
module mbs_master_model (
  // clock
  input  wire logic       clk,
  // query side
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  // reply side
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0]  got[$];   // reply bytes taken
  bit          slow = 0; // stall the transmitter
  int unsigned tick = 0; // stall pattern counter
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  function automatic logic [15:0] crc16(logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    end
    return c;
  endfunction
  // crc appended low byte first, optionally broken
  task automatic send(logic [7:0] q[$], bit bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = q[i];
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~q[i]; // stale data must not look valid
    end
  endtask
  // when slow, ready only one cycle in four
  always @(negedge clk) begin
    tick <= tick + 1;
    tx_ready <= !slow || (tick % 4 == 0);
  end
  // byte taken at the handshake edge
  always @(posedge clk) if (tx_valid === 1'b1 && tx_ready) got.push_back(tx_data);
endmodule // mbs_master_model

/* File: mbs_frame_engine_test.sv */
// self-checking bench for the slave frame engine
`timescale 1ns/1ps
module mbs_frame_engine_test;
  localparam int GAP = 20; // short idle gap for simulation
  logic clk = 0, sys_rst = 1, rx_valid, tx_valid, tx_ready, tx_en, reg_wr, relay_out, energy_clear;
  logic [7:0]  rx_data, tx_data, slave_addr = 8'h01;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  wire         reg_rd_ok, reg_wr_addr_ok, reg_wr_val_ok;
  int n_mismatch = 0, cmp_count = 0, n_clear = 0;
  // register file: readable below 0060, writable at 0004 and the energy pair
  assign reg_rdata = {reg_addr[7:0] ^ 8'h5a, reg_addr[7:0]};
  assign reg_rd_ok = reg_addr < 16'h0060;
  assign reg_wr_addr_ok = reg_addr == 16'h0004 || reg_addr == 16'h000c || reg_addr == 16'h000d;
  assign reg_wr_val_ok = reg_addr != 16'h0004 || reg_wdata[15:8] != 8'h00;
  always #5 clk = ~clk;
  always @(posedge clk) if (energy_clear === 1'b1) n_clear++;
  mbs_frame_engine #(.GAP_CYCLES(GAP)) u_mbs_frame_engine (.clk, .sys_rst, .rx_valid, .rx_data,
    .tx_valid, .tx_data, .tx_ready, .tx_en, .slave_addr, .reg_addr, .reg_wdata, .reg_wr, .reg_rdata,
    .reg_rd_ok, .reg_wr_addr_ok, .reg_wr_val_ok, .relay_out, .energy_clear);
  mbs_master_model u_mbs_master_model (.clk, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready);
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one query, then the whole reply (or silence when e is empty)
  task automatic xact(logic [7:0] q[$], logic [7:0] e[$], bit bad);
    int n;
    n = e.size() == 0 ? 0 : e.size() + 2;
    u_mbs_master_model.got.delete();
    u_mbs_master_model.send(q, bad);
    for (int t = 0; t < 1500 && (n == 0 || u_mbs_master_model.got.size() < n); t++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk(16'(u_mbs_master_model.got.size()), 16'(n));
    foreach (e[i]) chk({8'h00, u_mbs_master_model.got[i]}, {8'h00, e[i]});
    if (n > 0) chk({u_mbs_master_model.got[n-1], u_mbs_master_model.got[n-2]}, u_mbs_master_model.crc16(e));
  endtask
  task automatic t_read;
    xact('{8'h01, 8'h03, 8'h00, 8'h48, 8'h00, 8'h02}, '{8'h01, 8'h03, 8'h04, 8'h12, 8'h48, 8'h13, 8'h49}, 0);
  endtask
  // largest count with the far side stalling, so the fifo fills
  task automatic t_read_full;
    logic [7:0] e[$];
    e = '{8'h01, 8'h03, 8'h20};
    for (int i = 0; i < 16; i++) begin
      e.push_back(8'(8'h40 + i) ^ 8'h5a);
      e.push_back(8'(8'h40 + i));
    end
    u_mbs_master_model.slow = 1;
    xact('{8'h01, 8'h03, 8'h00, 8'h40, 8'h00, 8'h10}, e, 0);
    u_mbs_master_model.slow = 0;
    xact('{8'h01, 8'h03, 8'h00, 8'h40, 8'h00, 8'h11}, '{8'h01, 8'h83, 8'h83}, 0);
  endtask
  // host side writes only in-range values here
  task automatic t_clear;
    n_clear = 0;
    xact('{8'h01, 8'h10, 8'h00, 8'h0c, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00},
      '{8'h01, 8'h10, 8'h00, 8'h0c, 8'h00, 8'h02}, 0);
    chk(16'(n_clear), 16'h0001);
  endtask
  task automatic t_exc;
    xact('{8'h01, 8'h04, 8'h00, 8'h48, 8'h00, 8'h01}, '{8'h01, 8'h84, 8'h81}, 0);
    xact('{8'h01, 8'h03, 8'h01, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h83, 8'h82}, 0);
    xact('{8'h01, 8'h10, 8'h00, 8'h48, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, '{8'h01, 8'h90, 8'h82}, 0);
    xact('{8'h01, 8'h10, 8'h00, 8'h04, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01}, '{8'h01, 8'h90, 8'h83}, 0);
  endtask
  task automatic t_relay;
    xact('{8'h01, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00}, '{8'h01, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00}, 0);
    chk({15'h0000, relay_out}, 16'h0001);
    xact('{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h01, 8'h01, 8'h01, 8'h01}, 0);
    xact('{8'h01, 8'h05, 8'h00, 8'h00, 8'h12, 8'h34}, '{8'h01, 8'h85, 8'h83}, 0);
    xact('{8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
    chk({15'h0000, relay_out}, 16'h0000);
  endtask
  // foreign address, broadcast and a broken check field get no answer
  task automatic t_silent;
    xact('{8'h02, 8'h03, 8'h00, 8'h48, 8'h00, 8'h01}, '{}, 0);
    xact('{8'h00, 8'h03, 8'h00, 8'h48, 8'h00, 8'h01}, '{}, 0);
    xact('{8'h01, 8'h03, 8'h00, 8'h48, 8'h00, 8'h01}, '{}, 1);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_read;
    t_read_full;
    t_clear;
    t_exc;
    t_relay;
    t_silent;
    report_and_stop;
  end
  // watchdog well past the expected run length
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end
endmodule // mbs_frame_engine_test
